// ---- rptp_map.svh ----
// Register offsets, reset values and timing counts of the power-to-pulse datapath
`ifndef RPTP_MAP_SVH
`define RPTP_MAP_SVH
`define RPTP_SAMPLE_W 16
`define RPTP_OSR_KHZ 450
`define RPTP_CLK_MHZ 250
`define RPTP_SAMPLE_DIV ((`RPTP_CLK_MHZ * 1000) / `RPTP_OSR_KHZ)
`define RPTP_FIFO_DEPTH 8
`define RPTP_REG_CTRL 12'h000
`define RPTP_REG_STATUS 12'h004
`define RPTP_REG_THR_LOW 12'h008
`define RPTP_REG_THR_CAL 12'h00c
`define RPTP_REG_NOLOAD 12'h010
`define RPTP_REG_POWER 12'h014
`define RPTP_CTRL_RESET 32'h0000_0000
`define RPTP_THR_LOW_RESET 32'h0100_0000
`define RPTP_THR_CAL_RESET 32'h0000_8000
`define RPTP_NOLOAD_RESET 32'h0000_0010
`define RPTP_SUPPLY_FILT 8'h20
`define RPTP_PULSE_LEN 16'h0400
`define RPTP_HPF_SHIFT 8
`define RPTP_LPF_SHIFT 6
`endif

// ---- rptp_pkg.sv ----
// Types shared by the power-to-pulse datapath
package rptp_pkg;
   typedef enum logic [1:0] {RPTP_OFF, RPTP_RUN} rptp_state_t;
   typedef logic signed [31:0] rptp_power_t;
endpackage

// ---- rptp_fifo.sv ----
// Parameterised valid/ready sample FIFO
`timescale 1ns/1ns
module rptp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   // Empty from the occupancy count; ready comes from a flop fed by the next count
   assign out_valid = cnt_reg != '0;
   assign out_data = mem[rd_reg];
   // Pointer and count update
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_next;
         in_ready <= cnt_next != (AW+1)'(DEPTH); // Full refuses the next push
      end
   end
   // Storage write
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end
endmodule

// ---- rptp_core.sv ----
// Real power to pulse datapath with AXI4-Lite register slave
`timescale 1ns/1ns
`include "rptp_map.svh"
// Contract
// - Take 16-bit current and voltage samples at the 450 kHz rate.
// - High-pass filter only the current samples to remove dc.
// - Multiply filtered current by voltage on every sample.
// - Low-pass filter the product to extract real power.
// - Low-rate pulses come from long accumulation of real power.
// - Calibration pulse uses a much shorter accumulation period.
// - Stay inactive while the supply is below the trigger level.
// - Filter the supply indication with hysteresis against noise.
// - Negative-power flag follows power sign, updated at calibration pulses.
// - Calibration output held high during no-load.
module rptp_core
   import rptp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [15:0] current_channel,
   input wire logic [15:0] voltage_channel,
   input wire logic supply_ok,
   input wire logic pulse_scale_select_0,
   input wire logic pulse_scale_select_1,
   input wire logic calibration_rate_select,
   output logic low_rate_pulse_a,
   output logic low_rate_pulse_b,
   output logic calibration_pulse_out,
   output logic negative_power_flag,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Byte-lane merge used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            old[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return old;
   endfunction
   // Magnitude of a signed power word
   function automatic logic [31:0] mag(input rptp_power_t p);
      return p[31] ? 32'(-p) : 32'(p);
   endfunction

   rptp_state_t state_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] thr_low_reg;
   logic [31:0] thr_cal_reg;
   logic [31:0] noload_reg;
   logic [7:0] sup_cnt_reg;
   logic [15:0] div_reg;
   logic tick_reg;
   logic signed [15:0] i_prev_reg;
   logic signed [23:0] hpf_reg;
   rptp_power_t lpf_reg;
   logic [39:0] acc_low_reg;
   logic [31:0] acc_cal_reg;
   logic [15:0] low_w_reg;
   logic [15:0] cal_w_reg;
   logic low_phase_reg;
   logic noload_flag_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [11:0] aw_reg;
   logic [31:0] wd_reg;
   logic [3:0] ws_reg;

   // Sample FIFO between the converter stream and the 450 kHz datapath
   logic f_valid;
   logic [31:0] f_data;
   wire take = tick_reg && f_valid && state_reg == RPTP_RUN;
   rptp_fifo #(.WIDTH(32), .DEPTH(`RPTP_FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data({current_channel, voltage_channel}),
      .out_valid(f_valid),
      .out_ready(take),
      .out_data(f_data)
   );

   // Datapath arithmetic
   wire signed [15:0] cur_s = f_data[31:16];
   wire signed [15:0] vol_s = f_data[15:0];
   wire signed [23:0] hpf_next = hpf_reg - (hpf_reg >>> `RPTP_HPF_SHIFT)
      + 24'(cur_s) - 24'(i_prev_reg);
   wire signed [31:0] inst_pwr = 32'($signed(hpf_next[23:8])) * 32'(vol_s); // Slice re-signed before widening
   wire signed [31:0] lpf_next = lpf_reg + ((inst_pwr - lpf_reg) >>> `RPTP_LPF_SHIFT);
   wire [31:0] pwr_mag = mag(lpf_next);
   wire noload_now = pwr_mag < noload_reg;
   wire [1:0] scale = {pulse_scale_select_1, pulse_scale_select_0};
   wire [39:0] thr_low_eff = {thr_low_reg, 8'h00} >> scale;
   wire [31:0] thr_cal_eff = calibration_rate_select ? (thr_cal_reg >> 4) : thr_cal_reg;
   wire [39:0] acc_low_sum = acc_low_reg + 40'(pwr_mag);
   wire [31:0] acc_cal_sum = acc_cal_reg + pwr_mag;
   wire low_fire = acc_low_sum >= thr_low_eff;
   wire cal_fire = acc_cal_sum >= thr_cal_eff;
   wire sup_hi = sup_cnt_reg == `RPTP_SUPPLY_FILT;
   wire run_en = ctrl_reg[0];

   // Supply monitor: saturating counter, enter at top, leave at zero
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sup_cnt_reg <= '0;
         state_reg <= RPTP_OFF;
      end else begin
         if (supply_ok && !sup_hi) sup_cnt_reg <= sup_cnt_reg + 8'h01;
         else if (!supply_ok && sup_cnt_reg != 8'h00) sup_cnt_reg <= sup_cnt_reg - 8'h01;
         case (state_reg)
            RPTP_OFF: if (sup_hi && run_en) state_reg <= RPTP_RUN;
            RPTP_RUN: if (sup_cnt_reg == 8'h00 || !run_en) state_reg <= RPTP_OFF;
            default: state_reg <= RPTP_OFF;
         endcase
      end
   end

   // Sample-rate tick from the system clock
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= div_reg == 16'(`RPTP_SAMPLE_DIV - 1);
         div_reg <= (div_reg == 16'(`RPTP_SAMPLE_DIV - 1)) ? '0 : div_reg + 16'h0001;
      end
   end

   // Filters and accumulators, cleared while inactive
   always_ff @(posedge sys_clk) begin
      if (!nrst || state_reg != RPTP_RUN) begin
         i_prev_reg <= '0;
         hpf_reg <= '0;
         lpf_reg <= '0;
         acc_low_reg <= '0;
         acc_cal_reg <= '0;
         noload_flag_reg <= 1'b0;
      end else if (take) begin
         i_prev_reg <= cur_s;
         hpf_reg <= hpf_next;
         lpf_reg <= lpf_next;
         noload_flag_reg <= noload_now;
         if (!noload_now) begin
            acc_low_reg <= low_fire ? acc_low_sum - thr_low_eff : acc_low_sum;
            acc_cal_reg <= cal_fire ? acc_cal_sum - thr_cal_eff : acc_cal_sum;
         end
      end
   end

   // Pulse stretchers and output pins
   always_ff @(posedge sys_clk) begin
      if (!nrst || state_reg != RPTP_RUN) begin
         low_w_reg <= '0;
         cal_w_reg <= '0;
         low_phase_reg <= 1'b0;
         low_rate_pulse_a <= 1'b0;
         low_rate_pulse_b <= 1'b0;
         calibration_pulse_out <= 1'b0;
         negative_power_flag <= 1'b0;
      end else begin
         if (take && !noload_now && low_fire) begin
            low_w_reg <= `RPTP_PULSE_LEN;
            low_phase_reg <= !low_phase_reg;
         end else if (low_w_reg != 16'h0000) begin
            low_w_reg <= low_w_reg - 16'h0001;
         end
         if (take && !noload_now && cal_fire) begin
            cal_w_reg <= `RPTP_PULSE_LEN;
            negative_power_flag <= lpf_next[31];
         end else if (cal_w_reg != 16'h0000) begin
            cal_w_reg <= cal_w_reg - 16'h0001;
         end
         low_rate_pulse_a <= low_w_reg != 16'h0000 && !low_phase_reg;
         low_rate_pulse_b <= low_w_reg != 16'h0000 && low_phase_reg;
         calibration_pulse_out <= noload_flag_reg || cal_w_reg != 16'h0000;
      end
   end

   // AXI4-Lite write channel: address and data in either order
   wire [11:0] wa = aw_got_reg ? aw_reg : s_axi_awaddr;
   wire w_hit = wa == `RPTP_REG_CTRL || wa == `RPTP_REG_THR_LOW || wa == `RPTP_REG_THR_CAL
      || wa == `RPTP_REG_NOLOAD;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_reg <= '0;
         wd_reg <= '0;
         ws_reg <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         ctrl_reg <= `RPTP_CTRL_RESET;
         thr_low_reg <= `RPTP_THR_LOW_RESET;
         thr_cal_reg <= `RPTP_THR_CAL_RESET;
         noload_reg <= `RPTP_NOLOAD_RESET;
      end else begin
         s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wd_reg <= s_axi_wdata;
            ws_reg <= s_axi_wstrb;
         end
         if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? 2'b00 : 2'b10;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            if (aw_reg == `RPTP_REG_CTRL) ctrl_reg <= merge(ctrl_reg, wd_reg, ws_reg);
            if (aw_reg == `RPTP_REG_THR_LOW) thr_low_reg <= merge(thr_low_reg, wd_reg, ws_reg);
            if (aw_reg == `RPTP_REG_THR_CAL) thr_cal_reg <= merge(thr_cal_reg, wd_reg, ws_reg);
            if (aw_reg == `RPTP_REG_NOLOAD) noload_reg <= merge(noload_reg, wd_reg, ws_reg);
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel with status readback
   wire [31:0] status_word = {26'h0, noload_flag_reg, negative_power_flag, sup_hi, 2'b00,
      state_reg == RPTP_RUN};
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `RPTP_REG_CTRL: rd_mux = ctrl_reg;
         `RPTP_REG_STATUS: rd_mux = status_word;
         `RPTP_REG_THR_LOW: rd_mux = thr_low_reg;
         `RPTP_REG_THR_CAL: rd_mux = thr_cal_reg;
         `RPTP_REG_NOLOAD: rd_mux = noload_reg;
         `RPTP_REG_POWER: rd_mux = lpf_reg;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   a_off_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg != RPTP_RUN |=> !low_rate_pulse_a && !low_rate_pulse_b && !calibration_pulse_out)
      else $error("outputs active while inactive");
   a_supply_filter: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_OFF && !sup_hi |=> state_reg == RPTP_OFF)
      else $error("entered run without filtered supply");
   a_noload_high: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_RUN && $past(state_reg) == RPTP_RUN && noload_flag_reg |=> calibration_pulse_out)
      else $error("calibration output low in no-load");
   a_flag_update: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_RUN && $changed(negative_power_flag) |-> $past(take && cal_fire && !noload_now))
      else $error("flag changed without calibration pulse");
   a_cal_remainder: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_RUN && take && !noload_now && cal_fire |=> acc_cal_reg == $past(acc_cal_sum - thr_cal_eff))
      else $error("calibration remainder lost");
   a_low_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_RUN && take && !noload_now && low_fire |=> ##1 (low_rate_pulse_a || low_rate_pulse_b) || state_reg != RPTP_RUN)
      else $error("low-rate pulse missing");
   a_hpf_step: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == RPTP_RUN && take |=> hpf_reg == $past(hpf_next) || state_reg != RPTP_RUN)
      else $error("high-pass state not updated");
   a_one_pending: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
endmodule

// ---- rptp_pulse_counter.sv ----
// Pulse counter standing in for the meter counter or microcontroller port
`timescale 1ns/1ns
module rptp_pulse_counter (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic pulse_a,
   input wire logic pulse_b,
   input wire logic pulse_cal,
   output logic [15:0] count_a,
   output logic [15:0] count_b,
   output logic [15:0] count_cal
);
   logic [2:0] last_reg;
   // Rising edges are counted; a line held high counts once only
   always_ff @(posedge sys_clk) begin
      last_reg <= nrst ? {pulse_a, pulse_b, pulse_cal} : 3'h0;
      if (!nrst || clear) begin
         count_a <= 16'h0000;
         count_b <= 16'h0000;
         count_cal <= 16'h0000;
      end else begin
         count_a <= count_a + 16'(pulse_a & ~last_reg[2]);
         count_b <= count_b + 16'(pulse_b & ~last_reg[1]);
         count_cal <= count_cal + 16'(pulse_cal & ~last_reg[0]);
      end
   end
endmodule

// ---- tb_real_power_to_pulse_datapath.sv ----
// Self-checking bench for the power-to-pulse datapath
`timescale 1ns/1ns
`include "rptp_map.svh"
module tb_real_power_to_pulse_datapath
   import rptp_pkg::*;
;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic sample_valid = 1'b0;
   logic sample_ready;
   logic [15:0] current_channel = 16'h0000;
   logic [15:0] voltage_channel = 16'h0000;
   logic supply_ok = 1'b0;
   logic pulse_scale_select_0 = 1'b0;
   logic pulse_scale_select_1 = 1'b0;
   logic calibration_rate_select = 1'b0;
   logic low_rate_pulse_a, low_rate_pulse_b, calibration_pulse_out, negative_power_flag;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic phase_reg = 1'b0;
   logic signed [15:0] amp_i = 16'sh0000, amp_v = 16'sh0000;
   logic cnt_clear = 1'b0;
   logic [15:0] cnt_a, cnt_b, cnt_cal;
   int errors = 0, check_count = 0, cycles = 0, pushes = 0;
   localparam int TICK = 555;

   rptp_core uut (.sys_clk(sys_clk), .nrst(nrst), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .current_channel(current_channel), .voltage_channel(voltage_channel), .supply_ok(supply_ok),
      .pulse_scale_select_0(pulse_scale_select_0), .pulse_scale_select_1(pulse_scale_select_1),
      .calibration_rate_select(calibration_rate_select), .low_rate_pulse_a(low_rate_pulse_a),
      .low_rate_pulse_b(low_rate_pulse_b), .calibration_pulse_out(calibration_pulse_out),
      .negative_power_flag(negative_power_flag), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   rptp_pulse_counter counter (.sys_clk(sys_clk), .nrst(nrst), .clear(cnt_clear), .pulse_a(low_rate_pulse_a),
      .pulse_b(low_rate_pulse_b), .pulse_cal(calibration_pulse_out), .count_a(cnt_a), .count_b(cnt_b),
      .count_cal(cnt_cal));

   // Clock and hang guard
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         errors++;
         print_verdict();
      end
   end
   // Alternating sample pairs; a new pair only after the last was taken
   always @(posedge sys_clk) begin
      if (sample_valid && sample_ready === 1'b1) begin
         phase_reg <= ~phase_reg;
         pushes <= pushes + 1;
         current_channel <= phase_reg ? amp_i : -amp_i;
         voltage_channel <= phase_reg ? amp_v : -amp_v;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Waits for the answer however long; only the cycle guard ends a hang
   task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, input logic [1:0] exp);
      s_axi_awaddr <= addr;
      s_axi_wdata <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      check("bresp", 32'(s_axi_bresp), 32'(exp));
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic axi_read(input logic [11:0] addr, input logic [1:0] exp, output logic [31:0] data);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      check("rresp", 32'(s_axi_rresp), 32'(exp));
      data = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic clear_counts();
      cnt_clear <= 1'b1;
      @(posedge sys_clk);
      cnt_clear <= 1'b0;
   endtask
   function automatic logic [31:0] pins();
      return {28'h0, low_rate_pulse_a, low_rate_pulse_b, calibration_pulse_out, negative_power_flag};
   endfunction

   // Reset values, unmapped access refused
   task automatic t_reset();
      logic [31:0] d;
      logic [11:0] adr [4] = '{`RPTP_REG_CTRL, `RPTP_REG_THR_LOW, `RPTP_REG_THR_CAL, `RPTP_REG_NOLOAD};
      logic [31:0] rv [4] = '{`RPTP_CTRL_RESET, `RPTP_THR_LOW_RESET, `RPTP_THR_CAL_RESET, `RPTP_NOLOAD_RESET};
      check("pins after reset", pins(), 32'h0);
      for (int i = 0; i < 4; i++) begin
         axi_read(adr[i], 2'b00, d);
         check("reset value", d, rv[i]);
      end
      axi_read(12'h100, 2'b10, d);
      check("unmapped rdata", d, 32'h0);
      axi_write(12'h100, 32'h1, 2'b10);
      s_axi_wstrb <= 4'h1;
      axi_write(`RPTP_REG_NOLOAD, 32'h0000_ff40, 2'b00);
      s_axi_wstrb <= 4'hf;
      axi_read(`RPTP_REG_NOLOAD, 2'b00, d);
      check("byte strobe", d, 32'h0000_0040);
      axi_write(`RPTP_REG_NOLOAD, `RPTP_NOLOAD_RESET, 2'b00);
      $display("test reset done");
   endtask
   // Idle block leaves the sample buffer undrained until it refuses
   task automatic t_fill();
      sample_valid <= 1'b1;
      wait_cycles(30);
      check("pushes while idle", 32'(pushes), 32'd8);
      check("ready when full", {31'h0, sample_ready}, 32'h0);
      $display("test fill done");
   endtask
   // Supply indication needs a steady level to change state
   task automatic t_supply();
      logic [31:0] d;
      pulse_scale_select_1 <= 1'b1;
      axi_write(`RPTP_REG_CTRL, 32'h1, 2'b00);
      supply_ok <= 1'b1;
      wait_cycles(5);
      supply_ok <= 1'b0;
      wait_cycles(5);
      axi_read(`RPTP_REG_STATUS, 2'b00, d);
      check("short high ignored", d & 32'h9, 32'h0);
      supply_ok <= 1'b1;
      wait_cycles(40);
      supply_ok <= 1'b0;
      wait_cycles(5);
      supply_ok <= 1'b1;
      axi_read(`RPTP_REG_STATUS, 2'b00, d);
      check("short low ignored", d & 32'h9, 32'h1);
      $display("test supply done");
   endtask
   // Zero power keeps the calibration line high
   task automatic t_noload();
      logic [31:0] d;
      int low_seen;
      low_seen = 0;
      pulse_scale_select_1 <= 1'b0;
      wait_cycles(12 * TICK);
      clear_counts();
      repeat (2000) begin
         @(posedge sys_clk);
         if (calibration_pulse_out !== 1'b1) low_seen++;
      end
      check("cal held high", 32'(low_seen), 32'h0);
      check("no low pulses", {cnt_a, cnt_b}, 32'h0);
      axi_read(`RPTP_REG_STATUS, 2'b00, d);
      check("no-load status", d & 32'h20, 32'h20);
      $display("test noload done");
   endtask
   // In-phase channels give positive power and pulse trains
   task automatic t_positive();
      logic [31:0] d;
      pulse_scale_select_0 <= 1'b1;
      axi_write(`RPTP_REG_THR_LOW, 32'h400, 2'b00);
      axi_write(`RPTP_REG_THR_CAL, 32'h1_0000, 2'b00);
      axi_read(`RPTP_REG_THR_CAL, 2'b00, d);
      check("cal threshold", d, 32'h1_0000);
      amp_i <= 16'sd4000;
      amp_v <= 16'sd4000;
      clear_counts();
      wait_cycles(45 * TICK);
      axi_read(`RPTP_REG_POWER, 2'b00, d);
      check("power positive", {31'h0, $signed(d) > 0}, 32'h1);
      check("flag low", {31'h0, negative_power_flag}, 32'h0);
      check("cal pulses", {31'h0, cnt_cal >= 16'd2}, 32'h1);
      check("low pulses", {31'h0, cnt_a >= 16'd1}, 32'h1);
      check("low alternate", {31'h0, cnt_b == cnt_a || cnt_b == cnt_a + 16'd1}, 32'h1);
      check("cal faster", {31'h0, cnt_cal > cnt_a + cnt_b}, 32'h1);
      supply_ok <= 1'b0;
      wait_cycles(40);
      check("pins when low supply", pins(), 32'h0);
      axi_read(`RPTP_REG_STATUS, 2'b00, d);
      check("stopped", d & 32'h1, 32'h0);
      supply_ok <= 1'b1;
      wait_cycles(40);
      $display("test positive done");
   endtask
   // Inverted voltage gives negative power and raises the flag
   task automatic t_negative();
      logic [31:0] d;
      pulse_scale_select_1 <= 1'b1;
      calibration_rate_select <= 1'b1;
      amp_v <= -16'sd4000;
      clear_counts();
      wait_cycles(45 * TICK);
      axi_read(`RPTP_REG_POWER, 2'b00, d);
      check("power negative", {31'h0, $signed(d) < 0}, 32'h1);
      check("flag high", {31'h0, negative_power_flag}, 32'h1);
      check("cal pulses", {31'h0, cnt_cal >= 16'd1}, 32'h1);
      $display("test negative done");
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_fill();
      t_supply();
      t_noload();
      t_positive();
      t_negative();
      print_verdict();
   end
endmodule
